// File: common/hold_clear_defs.svh
// constants for the faulty-station hold/clear policy block
`ifndef HOLD_CLEAR_DEFS_SVH
`define HOLD_CLEAR_DEFS_SVH

// ****************************************
// sizes
// ****************************************
`define STN_NUM 4
`define STN_W 2
`define AREA_W 2
`define SLOT_NUM 16
`define SLOT_W 4
`define DATA_W 16

// ****************************************
// receive area codes inside one station
// ****************************************
`define AREA_IN 2'h0
`define AREA_OUT 2'h1
`define AREA_WR 2'h2
`define AREA_RD 2'h3

// ****************************************
// reset values
// ****************************************
`define DATA_CLEAR 16'h0000
`define SLOT_ZERO 4'h0

`endif

// File: common/hold_clear_pkg.sv
// types for the faulty-station hold/clear policy block
`include "hold_clear_defs.svh"

package hold_clear_pkg;

    // kind of peer station sitting on one station number
    typedef enum logic [1:0] {
        STN_REMOTE_IO = 2'h0,
        STN_REMOTE_DEV = 2'h1,
        STN_LOCAL = 2'h2
    } stn_kind_t;

    // clear sweep machine
    typedef enum logic [1:0] {
        SWP_IDLE = 2'h1,
        SWP_CLEAR = 2'h2
    } sweep_state_t;

    // whole state of the policy block
    typedef struct packed {
        logic [`STN_NUM-1:0] err;
        logic [`STN_NUM-1:0] lstop;
        logic mstop;
        logic lkstop;
        logic [`SLOT_NUM-1:0] pend;
        logic [`SLOT_NUM-1:0] held;
        logic rx_ready;
        sweep_state_t swp;
        logic [`SLOT_W-1:0] slot;
    } policy_state_t;

    // whole state of the area memory read side
    typedef struct packed {
        logic [`DATA_W-1:0] rd_data;
    } mem_state_t;

endpackage

// File: verilog/rx_area_mem.sv
// receive area memory, one word per station and area, registered read
`timescale 1ns/1ps
`include "hold_clear_defs.svh"

module rx_area_mem
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic we,
    input wire logic [`SLOT_W-1:0] waddr,
    input wire logic [`DATA_W-1:0] wdata,
    input wire logic [`SLOT_W-1:0] raddr,
    output logic [`DATA_W-1:0] rdata
);
    import hold_clear_pkg::*;

    // ****************************************
    // storage
    // ****************************************
    logic [`DATA_W-1:0] mem_reg [`SLOT_NUM];
    mem_state_t st_reg;
    mem_state_t st_next;

    // read data latched so the consumer sees a flop
    always_comb
    begin
        st_next = st_reg;
        st_next.rd_data = mem_reg[raddr];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_reg <= '0;
        else if (ce)
            st_reg <= st_next;
    end

    // array not reset: the policy block sweeps it when it matters
    always_ff @(posedge clk)
    begin
        if (ce && we)
            mem_reg[waddr] <= wdata;
    end

    assign rdata = st_reg.rd_data;
endmodule

// File: verilog/hold_clear_policy.sv
// faulty-station hold/clear policy for the cyclic receive areas
`timescale 1ns/1ps
`include "hold_clear_defs.svh"

module hold_clear_policy
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic setting_valid,
    input wire logic setting_hold,
    input wire logic param_by_instr,
    input wire logic refresh_to_output_dev,
    input wire logic is_local,
    input wire logic [`STN_W-1:0] own_station,
    input wire hold_clear_pkg::stn_kind_t station_kind [`STN_NUM],
    input wire logic [`STN_NUM-1:0] station_err,
    input wire logic [`STN_NUM-1:0] local_cpu_stop,
    input wire logic master_cpu_stop,
    input wire logic link_stop,
    input wire logic rx_valid,
    input wire logic [`STN_W-1:0] rx_station,
    input wire logic [`AREA_W-1:0] rx_area,
    input wire logic [`DATA_W-1:0] rx_data,
    input wire logic [`STN_W-1:0] rd_station,
    input wire logic [`AREA_W-1:0] rd_area,
    output logic [`DATA_W-1:0] rd_data,
    output logic rx_ready,
    output logic [`SLOT_NUM-1:0] area_held,
    output logic clear_busy
);
    import hold_clear_pkg::*;

    // ****************************************
    // state and decode
    // ****************************************
    policy_state_t st_reg;
    policy_state_t st_next;
    logic hold_eff;
    logic mstop_rise;
    logic lk_rise;
    logic [`SLOT_NUM-1:0] frozen;
    logic [`SLOT_NUM-1:0] set_clr;
    logic [`SLOT_W-1:0] rx_slot;
    logic link_we;
    logic mem_we;
    logic [`SLOT_W-1:0] mem_addr;
    logic [`DATA_W-1:0] mem_wdata;

    // unconfigured setting falls back to clear
    assign hold_eff = setting_valid & setting_hold;
    assign mstop_rise = master_cpu_stop & ~st_reg.mstop;
    assign lk_rise = link_stop & ~st_reg.lkstop;
    assign rx_slot = {rx_station, rx_area};

    // ****************************************
    // per station freeze and clear triggers
    // ****************************************
    genvar s;
    generate
        for (s = 0; s < `STN_NUM; s = s + 1)
        begin : g_stn
            logic err_rise;
            logic lstop_rise;
            logic lk_local;
            logic other_stn;
            assign err_rise = station_err[s] & ~st_reg.err[s];
            assign lstop_rise = local_cpu_stop[s] & ~st_reg.lstop[s];
            assign lk_local = st_reg.lkstop & is_local;
            assign other_stn = (own_station != `STN_W'(s));
            // input area: no update while the peer is faulty, cleared or held
            assign frozen[s*4+0] = st_reg.err[s];
            assign set_clr[s*4+0] = err_rise & ~hold_eff;
            // output area: a local stop touches only that station's own area; master and link stops reach other stations' areas
            assign frozen[s*4+1] = (st_reg.mstop & ~is_local)
                | (st_reg.lstop[s] & refresh_to_output_dev)
                | lk_local;
            assign set_clr[s*4+1] =
                (mstop_rise & ~is_local & ~param_by_instr & refresh_to_output_dev)
                | (lstop_rise & refresh_to_output_dev)
                | (lk_rise & is_local & ~hold_eff & other_stn);
            // write words keep running unless the whole link stops at a local station
            assign frozen[s*4+2] = lk_local;
            assign set_clr[s*4+2] = 1'b0;
            // read words retained for faulty device or local peers
            assign frozen[s*4+3] = (st_reg.err[s] & (station_kind[s] != STN_REMOTE_IO))
                | lk_local;
            assign set_clr[s*4+3] = 1'b0;
        end
    endgenerate

    // link writes only land on live, non-pending slots
    assign link_we = rx_valid & st_reg.rx_ready & ~frozen[rx_slot] & ~st_reg.pend[rx_slot];

    // ****************************************
    // memory write mux
    // ****************************************
    // the sweep owns the port; rx_ready is low meanwhile so nothing is lost
    always_comb
    begin
        mem_we = 1'b0;
        mem_addr = rx_slot;
        mem_wdata = rx_data;
        if (st_reg.swp == SWP_CLEAR)
        begin
            mem_we = 1'b1;
            mem_addr = st_reg.slot;
            mem_wdata = `DATA_CLEAR;
        end
        else if (link_we)
        begin
            mem_we = 1'b1;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [`SLOT_NUM-1:0] pend_n;
        logic [`SLOT_W-1:0] pick;
        pend_n = st_reg.pend;
        pick = `SLOT_ZERO;
        st_next = st_reg;
        st_next.err = station_err;
        st_next.lstop = local_cpu_stop;
        st_next.mstop = master_cpu_stop;
        st_next.lkstop = link_stop;
        st_next.held = frozen;
        // retire the slot just cleared; a new trigger in this cycle wins
        if (st_reg.swp == SWP_CLEAR)
            pend_n[st_reg.slot] = 1'b0;
        pend_n = pend_n | set_clr;
        st_next.pend = pend_n;
        // lowest pending slot goes first
        for (int i = `SLOT_NUM - 1; i >= 0; i--)
        begin
            if (pend_n[i])
                pick = i[`SLOT_W-1:0];
        end
        st_next.slot = pick;
        unique case (st_reg.swp)
            SWP_IDLE:
            begin
                if (|st_reg.pend)
                    st_next.swp = SWP_CLEAR;
            end
            SWP_CLEAR:
            begin
                if (!(|pend_n))
                    st_next.swp = SWP_IDLE;
            end
            default:
            begin
                st_next.swp = SWP_IDLE;
            end
        endcase
        // pick must point at the current pend when entering the sweep
        if (st_reg.swp == SWP_IDLE)
        begin
            for (int i = `SLOT_NUM - 1; i >= 0; i--)
            begin
                if (st_reg.pend[i])
                    st_next.slot = i[`SLOT_W-1:0];
            end
        end
        st_next.rx_ready = (st_next.swp == SWP_IDLE) && !(|pend_n);
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
            st_reg.swp <= SWP_IDLE;
            st_reg.rx_ready <= 1'b1;
        end
        else if (ce)
            st_reg <= st_next;
    end

    // ****************************************
    // memory and outputs
    // ****************************************
    rx_area_mem u_mem
    (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .we(mem_we),
        .waddr(mem_addr),
        .wdata(mem_wdata),
        .raddr({rd_station, rd_area}),
        .rdata(rd_data)
    );

    assign rx_ready = st_reg.rx_ready;
    assign area_held = st_reg.held;
    assign clear_busy = st_reg.swp[1]; // one-hot bit of the clear state, no decode

    // ****************************************
    // checks
    // ****************************************
    AST_IN_CLEAR: assert property (@(posedge clk) disable iff (rst)
        ce && station_err[0] && !st_reg.err[0] && hold_eff == 1'b0 |=> st_reg.pend[0])
        else $error("input area of faulty station 0 not queued for clear");

    AST_DEFAULT_CLEAR: assert property (@(posedge clk) disable iff (rst)
        ce && station_err[0] && !st_reg.err[0] && !setting_valid |=> st_reg.pend[0])
        else $error("unconfigured setting did not clear");

    AST_IN_HOLD: assert property (@(posedge clk) disable iff (rst)
        ce && hold_eff && station_err[1] && !st_reg.err[1] && !st_reg.pend[4]
        |=> !st_reg.pend[4])
        else $error("hold setting cleared an input area");

    AST_RD_RETAIN: assert property (@(posedge clk) disable iff (rst)
        st_reg.err[1] && station_kind[1] == STN_REMOTE_DEV |-> frozen[7] && !(link_we && rx_slot == 4'h7))
        else $error("read words of faulty device station updated");

    AST_MSTOP_CLEAR: assert property (@(posedge clk) disable iff (rst)
        ce && mstop_rise && !is_local && !param_by_instr && refresh_to_output_dev
        |=> st_reg.pend[1] && st_reg.pend[13] ##1 clear_busy)
        else $error("output areas not cleared on master stop");

    AST_LSTOP_ONLY: assert property (@(posedge clk) disable iff (rst)
        ce && local_cpu_stop[3] && !st_reg.lstop[3] && refresh_to_output_dev
        && !set_clr[9] && !st_reg.pend[9]
        |=> st_reg.pend[13] && !st_reg.pend[9])
        else $error("local stop clear hit the wrong station");

    AST_OTHERS_RUN: assert property (@(posedge clk) disable iff (rst)
        st_reg.lstop[3] && !st_reg.err[0] && !st_reg.mstop && !st_reg.lkstop && !st_reg.lstop[0]
        |-> !frozen[0] && !frozen[1] && !frozen[2] && !frozen[3])
        else $error("other station frozen by a local stop");

    AST_LINK_CLEAR: assert property (@(posedge clk) disable iff (rst)
        ce && lk_rise && is_local && !hold_eff && own_station == 2'h0
        && !st_reg.pend[1] && !set_clr[1]
        |=> st_reg.pend[13] && !st_reg.pend[1])
        else $error("link stop clear wrong at local station");

    AST_LINK_RETAIN: assert property (@(posedge clk) disable iff (rst)
        st_reg.lkstop && is_local |-> frozen[2] && frozen[3] && frozen[14] && frozen[15])
        else $error("word areas not retained on link stop");

    AST_SWEEP_ZERO: assert property (@(posedge clk) disable iff (rst)
        clear_busy |-> mem_we && mem_wdata == 16'h0000 && !link_we)
        else $error("clear sweep did not write zero");
endmodule

// File: tb/link_peer_model.sv
// far-side peer that pushes cyclic words into the receive areas
`timescale 1ns/1ps
`include "hold_clear_defs.svh"

module link_peer_model
(
    input wire logic send,
    input wire logic [`STN_W-1:0] stn,
    input wire logic [`AREA_W-1:0] area,
    input wire logic [`DATA_W-1:0] data,
    output logic rx_valid,
    output logic [`STN_W-1:0] rx_station,
    output logic [`AREA_W-1:0] rx_area,
    output logic [`DATA_W-1:0] rx_data
);
    // between words the data lines show the inverse of the last word, never the word itself
    always_comb
    begin
        rx_valid = send;
        rx_station = stn;
        rx_area = area;
        rx_data = send ? data : ~data;
    end
endmodule

// File: tb/tb_hold_clear_policy.sv
// self-checking bench for the hold/clear policy block
`timescale 1ns/1ps
`include "hold_clear_defs.svh"

module tb_hold_clear_policy;
    import hold_clear_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic setting_valid = 1'b0;
    logic setting_hold = 1'b0;
    logic param_by_instr = 1'b0;
    logic refresh_to_output_dev = 1'b0;
    logic is_local = 1'b0;
    logic [1:0] own_station = 2'h0;
    stn_kind_t station_kind [`STN_NUM] = '{STN_REMOTE_IO, STN_REMOTE_DEV, STN_LOCAL, STN_LOCAL};
    logic [3:0] station_err = 4'h0;
    logic [3:0] local_cpu_stop = 4'h0;
    logic master_cpu_stop = 1'b0;
    logic link_stop = 1'b0;
    logic send = 1'b0;
    logic [1:0] tx_stn = 2'h0;
    logic [1:0] tx_area = 2'h0;
    logic [15:0] tx_data = 16'h0000;
    logic [1:0] rd_station = 2'h0;
    logic [1:0] rd_area = 2'h0;
    logic rx_valid;
    logic [1:0] rx_station;
    logic [1:0] rx_area;
    logic [15:0] rx_data;
    logic [15:0] rd_data;
    logic rx_ready;
    logic [15:0] area_held;
    logic clear_busy;
    logic [15:0] expv [16];
    int mismatches = 0;
    int comparisons = 0;

    // ****
    // clock, peer and block under test
    // ****
    always #10 clk = ~clk;

    link_peer_model peer (.send(send), .stn(tx_stn), .area(tx_area), .data(tx_data),
        .rx_valid(rx_valid), .rx_station(rx_station), .rx_area(rx_area), .rx_data(rx_data));

    hold_clear_policy uut (.clk(clk), .rst(rst), .ce(ce), .setting_valid(setting_valid),
        .setting_hold(setting_hold), .param_by_instr(param_by_instr),
        .refresh_to_output_dev(refresh_to_output_dev), .is_local(is_local),
        .own_station(own_station), .station_kind(station_kind), .station_err(station_err),
        .local_cpu_stop(local_cpu_stop), .master_cpu_stop(master_cpu_stop),
        .link_stop(link_stop), .rx_valid(rx_valid), .rx_station(rx_station),
        .rx_area(rx_area), .rx_data(rx_data), .rd_station(rd_station), .rd_area(rd_area),
        .rd_data(rd_data), .rx_ready(rx_ready), .area_held(area_held),
        .clear_busy(clear_busy));

    // ****
    // helpers
    // ****
    function automatic int slot(input int s, input logic [1:0] a);
        return s * 4 + a;
    endfunction

    task tick;
        @(posedge clk);
        #2;
    endtask

    task chk(input string what, input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask

    task close_out;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // strobe stays up across back-to-back words; wr_end drops it
    task wr(input int s, input logic [1:0] a, input logic [15:0] d);
        send = 1'b1;
        tx_stn = s[1:0];
        tx_area = a;
        tx_data = d;
        tick;
    endtask

    task wr_end;
        send = 1'b0;
        tick;
    endtask

    task fill;
        for (int i = 0; i < 16; i++)
        begin
            expv[i] = 16'($urandom);
            wr(i / 4, 2'(i), expv[i]);
        end
        wr_end;
    endtask

    // reads every slot through the registered port
    task check_all;
        for (int i = 0; i < 16; i++)
        begin
            rd_station = 2'(i / 4);
            rd_area = 2'(i);
            tick;
            chk("slot data", rd_data, expv[i]);
        end
    endtask

    // waits out any clear sweep, bounded
    task settle;
        int n;
        n = 0;
        tick;
        tick;
        while ((rx_ready !== 1'b1 || clear_busy !== 1'b0) && n < 60)
        begin
            tick;
            n++;
        end
        if (n >= 60)
        begin
            mismatches++;
            close_out;
        end
    endtask

    // ****
    // scenarios
    // ****
    initial
    begin
        logic [15:0] d;
        logic [15:0] want;
        void'($urandom(32'h5f88f457));
        repeat (10) tick;
        rst = 1'b0;
        chk("ready", {15'h0, rx_ready}, 16'h0001);
        chk("held", area_held, 16'h0000);
        // peer error per kind: unconfigured, hold, clear
        for (int s = 0; s < 3; s++)
        begin
            setting_valid = (s != 0);
            setting_hold = (s == 1);
            fill;
            station_err[s] = 1'b1;
            settle;
            if (s != 1)
                expv[slot(s, `AREA_IN)] = 16'h0000;
            want = 16'h0001 << slot(s, `AREA_IN);
            if (s != 0)
                want = want | (16'h0001 << slot(s, `AREA_RD));
            tick;
            chk("held", area_held, want);
            wr(s, `AREA_IN, 16'($urandom));
            d = 16'($urandom);
            wr(s, `AREA_RD, d);
            if (s == 0)
                expv[slot(s, `AREA_RD)] = d;
            d = 16'($urandom);
            wr(s, `AREA_OUT, d);
            expv[slot(s, `AREA_OUT)] = d;
            d = 16'($urandom);
            wr(3, `AREA_IN, d);
            expv[slot(3, `AREA_IN)] = d;
            wr_end;
            check_all;
            station_err = 4'h0;
            tick;
            tick;
        end
        // master processor stop: by instruction then by tool
        fill;
        refresh_to_output_dev = 1'b1;
        param_by_instr = 1'b1;
        master_cpu_stop = 1'b1;
        settle;
        check_all;
        master_cpu_stop = 1'b0;
        tick;
        tick;
        param_by_instr = 1'b0;
        master_cpu_stop = 1'b1;
        // four output areas, one slot zeroed per cycle, link refused meanwhile
        tick;
        chk("ready on trigger", {15'h0, rx_ready}, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            tick;
            chk("busy in sweep", {15'h0, clear_busy}, 16'h0001);
        end
        tick;
        chk("busy after sweep", {15'h0, clear_busy}, 16'h0000);
        chk("ready after sweep", {15'h0, rx_ready}, 16'h0001);
        for (int s = 0; s < 4; s++)
            expv[slot(s, `AREA_OUT)] = 16'h0000;
        check_all;
        master_cpu_stop = 1'b0;
        tick;
        tick;
        // one local processor stops, the rest keep updating
        fill;
        local_cpu_stop[3] = 1'b1;
        settle;
        expv[slot(3, `AREA_OUT)] = 16'h0000;
        wr(3, `AREA_OUT, 16'($urandom));
        for (int i = 0; i < 3; i++)
        begin
            d = 16'($urandom);
            wr(i, `AREA_OUT, d);
            expv[slot(i, `AREA_OUT)] = d;
        end
        wr_end;
        check_all;
        local_cpu_stop = 4'h0;
        tick;
        tick;
        // whole link stop seen at a local station, clear setting
        fill;
        is_local = 1'b1;
        setting_valid = 1'b1;
        setting_hold = 1'b0;
        link_stop = 1'b1;
        settle;
        for (int s = 1; s < 4; s++)
            expv[slot(s, `AREA_OUT)] = 16'h0000;
        wr(2, `AREA_WR, 16'($urandom));
        wr(2, `AREA_RD, 16'($urandom));
        wr_end;
        check_all;
        link_stop = 1'b0;
        tick;
        // clock enable low: a word offered then must not land, later one must
        ce = 1'b0;
        wr(0, `AREA_WR, 16'($urandom));
        wr_end;
        ce = 1'b1;
        d = 16'($urandom);
        wr(0, `AREA_WR, d);
        expv[slot(0, `AREA_WR)] = d;
        wr_end;
        check_all;
        close_out;
    end
endmodule
